//--- design/ddbc_pkg.sv
/*
 shared constants for the double-buffer dma channel: mode codes, register offsets,
 status bit positions and reset values.
 assumes a single clock clk_sys at 20 mhz and a synchronous active-high reset.
*/
package ddbc_pkg;
   localparam int DDBC_AW = 32;
   localparam int DDBC_DW = 32;
   localparam logic [3:0] DDBC_MODE_NONE = 4'h0;
   localparam logic [3:0] DDBC_MODE_SRC_SW = 4'h8;
   localparam logic [3:0] DDBC_MODE_SRC_HW = 4'h9;
   localparam logic [3:0] DDBC_MODE_DST_SW = 4'hA;
   localparam logic [3:0] DDBC_MODE_DST_HW = 4'hB;
   localparam logic [3:0] DDBC_OFS_MODE = 4'h0;
   localparam logic [3:0] DDBC_OFS_CTRL = 4'h1;
   localparam logic [3:0] DDBC_OFS_STATE = 4'h2;
   localparam logic [3:0] DDBC_OFS_PTR0 = 4'h3;
   localparam logic [3:0] DDBC_OFS_PTR1 = 4'h4;
   localparam logic [3:0] DDBC_OFS_FIXED = 4'h5;
   localparam logic [3:0] DDBC_OFS_COUNT = 4'h6;
   localparam logic [3:0] DDBC_OFS_IRQ_STAT = 4'h7;
   localparam logic [3:0] DDBC_OFS_IRQ_MASK = 4'h8;
   localparam int DDBC_CTRL_HALT_REQ = 0;
   localparam int DDBC_CTRL_HALT_CLR = 1;
   localparam int DDBC_CTRL_SWITCH = 2;
   localparam int DDBC_CTRL_SET_REQ = 3;
   localparam int DDBC_ST_HALT_ACK = 0;
   localparam int DDBC_ST_PENDING = 1;
   localparam int DDBC_ST_FROZEN = 2;
   localparam int DDBC_ST_LOST = 3;
   localparam int DDBC_ST_ACTIVE = 4;
   localparam int DDBC_ST_STOPPED = 5;
   localparam int DDBC_EV_DONE = 0;
   localparam int DDBC_EV_LOST = 1;
   localparam int DDBC_EV_STOP = 2;
   localparam int DDBC_EV_W = 3;
   localparam logic [31:0] DDBC_PTR_RESET = 32'h0000_0000;
   localparam logic [15:0] DDBC_COUNT_RESET = 16'h0010;
endpackage

//--- design/ddbc_if.sv
/*
 link between the dma channel and the system bus memory side plus request source.
 assumes both ends share clk_sys; one move is a word write, ended by bus_ack.
*/
`timescale 1ns/1ns
interface ddbc_if (
   input wire logic clk_sys
);
   import ddbc_pkg::*;
   logic hw_req;
   logic bus_req;
   logic bus_we;
   logic [DDBC_AW-1:0] bus_addr;
   logic [DDBC_DW-1:0] bus_wdata;
   logic [DDBC_DW-1:0] bus_rdata;
   logic bus_ack;
   modport channel (
      input hw_req,
      output bus_req,
      output bus_we,
      output bus_addr,
      output bus_wdata,
      input bus_rdata,
      input bus_ack
   );
   modport memory (
      output hw_req,
      input bus_req,
      input bus_we,
      input bus_addr,
      input bus_wdata,
      output bus_rdata,
      output bus_ack
   );
endinterface

//--- design/ddbc_word_merge.sv
/*
 merges a word write into a 32-bit pointer; partial-width writes are ignored whole.
 assumes byte enables arrive with the write strobe.
*/
`timescale 1ns/1ns
module ddbc_word_merge
   import ddbc_pkg::*;
(
   input wire logic [DDBC_DW-1:0] old_value,
   input wire logic [DDBC_DW-1:0] wr_data,
   input wire logic [3:0] wr_be,
   output logic [DDBC_DW-1:0] new_value,
   output logic partial
);
   always_comb begin
      partial = (wr_be != 4'hF);
      new_value = partial ? old_value : wr_data;
   end
endmodule

//--- design/ddbc_channel.sv
/*
 double-buffer dma channel: software register port, buffer switch, halt, requests.
 assumes a memory end on ddbc_if that acks each move; hw_req is a same-clock pulse.
*/
// Functional notes
// - mode 1000/1001 selects double source buffering
// - mode 1010/1011 selects double destination buffering
// - software-only mode stops at buffer end
// - software writes pointers as whole words
// - switch keeps pending request, no split
// - dropped request sets request lost flag
// - halt request halts, then acknowledge reads one
// - pending request state bit is readable
// - switch exchanges buffer, frozen then reads one
// - set request raises pending software request
// - halt clear resumes a halted channel
// - software follows the seven-step switch sequence
// - software watches overflow and lost flags
`timescale 1ns/1ns
module ddbc_channel
   import ddbc_pkg::*;
#(
   parameter int CW = 16
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [DDBC_DW-1:0] reg_wdata,
   input wire logic [3:0] reg_be,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [DDBC_DW-1:0] reg_rdata,
   output logic irq,
   ddbc_if.channel link
);
   typedef enum logic [2:0] {
      DDBC_IDLE = 3'b001,
      DDBC_MOVE = 3'b010,
      DDBC_HALTED = 3'b100
   } ddbc_state_e;
   ddbc_state_e state_reg;
   logic [3:0] shadow_control_mode_reg;
   logic [DDBC_AW-1:0] ptr_reg [2];
   logic [DDBC_AW-1:0] fixed_reg;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] index_reg;
   logic active_reg;
   logic frozen_reg;
   logic stopped_reg;
   logic pending_request_state_reg;
   logic request_lost_flag_reg;
   logic halt_req_reg;
   logic halt_acknowledge_reg;
   logic [DDBC_EV_W-1:0] irq_stat_reg;
   logic [DDBC_EV_W-1:0] irq_mask_reg;
   logic bus_req_reg;
   logic bus_we_reg;
   logic [DDBC_AW-1:0] bus_addr_reg;
   logic [DDBC_DW-1:0] bus_wdata_reg;
   logic [DDBC_DW-1:0] merged;
   logic start_move;
   logic wr_partial;
   logic wr_ctrl;
   logic double_mode;
   logic dst_mode;
   logic hw_switch;
   logic move_done;
   logic last_move;
   logic sw_switch;
   logic set_req;
   logic [DDBC_EV_W-1:0] events;

   ddbc_word_merge u_merge (
      .old_value(ptr_reg[reg_addr == DDBC_OFS_PTR1]),
      .wr_data(reg_wdata),
      .wr_be(reg_be),
      .new_value(merged),
      .partial(wr_partial)
   );

   assign wr_ctrl = reg_write && reg_addr == DDBC_OFS_CTRL;
   assign sw_switch = wr_ctrl && reg_wdata[DDBC_CTRL_SWITCH];
   assign set_req = wr_ctrl && reg_wdata[DDBC_CTRL_SET_REQ];
   assign double_mode = shadow_control_mode_reg[3:2] == 2'b10;
   assign dst_mode = shadow_control_mode_reg[1];
   assign hw_switch = shadow_control_mode_reg[0];
   assign move_done = state_reg == DDBC_MOVE && link.bus_ack;
   // a switch or software request in the same cycle holds the move back
   assign start_move = state_reg == DDBC_IDLE && pending_request_state_reg && !halt_req_reg
      && !stopped_reg && !set_req && !sw_switch;
   assign last_move = index_reg == count_reg - CW'(1);
   assign events[DDBC_EV_DONE] = move_done && last_move;
   assign events[DDBC_EV_LOST] = link.hw_req && pending_request_state_reg && !start_move;
   assign events[DDBC_EV_STOP] = move_done && last_move && double_mode && !hw_switch;

   // mode, pointers, fixed address and count; pointers take whole words only
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         shadow_control_mode_reg <= DDBC_MODE_NONE;
         ptr_reg[0] <= DDBC_PTR_RESET;
         ptr_reg[1] <= DDBC_PTR_RESET;
         fixed_reg <= DDBC_PTR_RESET;
         count_reg <= CW'(DDBC_COUNT_RESET);
      end else if (reg_write) begin
         case (reg_addr)
            DDBC_OFS_MODE: shadow_control_mode_reg <= reg_wdata[3:0];
            DDBC_OFS_PTR0: if (!wr_partial) ptr_reg[0] <= merged;
            DDBC_OFS_PTR1: if (!wr_partial) ptr_reg[1] <= merged;
            DDBC_OFS_FIXED: fixed_reg <= reg_wdata;
            DDBC_OFS_COUNT: count_reg <= reg_wdata[CW-1:0];
            default: ;
         endcase
      end
   end

   // pending request: set wins over the service clear
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pending_request_state_reg <= 1'b0;
      end else if (link.hw_req || set_req) begin
         pending_request_state_reg <= 1'b1;
      end else if (start_move) begin
         pending_request_state_reg <= 1'b0;
      end
   end

   // request lost flag, write one to clear; set wins
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         request_lost_flag_reg <= 1'b0;
      end else if (events[DDBC_EV_LOST]) begin
         request_lost_flag_reg <= 1'b1;
      end else if (reg_write && reg_addr == DDBC_OFS_STATE && reg_wdata[DDBC_ST_LOST]) begin
         request_lost_flag_reg <= 1'b0;
      end
   end

   // halt request and acknowledge
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         halt_req_reg <= 1'b0;
      end else if (wr_ctrl && reg_wdata[DDBC_CTRL_HALT_CLR]) begin
         halt_req_reg <= 1'b0;
      end else if (wr_ctrl && reg_wdata[DDBC_CTRL_HALT_REQ]) begin
         halt_req_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         halt_acknowledge_reg <= 1'b0;
      end else begin
         halt_acknowledge_reg <= halt_req_reg && state_reg != DDBC_MOVE;
      end
   end

   // buffer switch: only between moves, so data never splits
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         active_reg <= 1'b0;
         frozen_reg <= 1'b0;
         stopped_reg <= 1'b0;
         index_reg <= '0;
      end else if (sw_switch && double_mode && state_reg != DDBC_MOVE) begin
         active_reg <= !active_reg;
         frozen_reg <= 1'b1;
         stopped_reg <= 1'b0;
         index_reg <= '0;
      end else if (move_done) begin
         frozen_reg <= 1'b0;
         if (last_move) begin
            index_reg <= '0;
            if (double_mode && hw_switch) begin
               active_reg <= !active_reg;
            end else if (double_mode) begin
               stopped_reg <= 1'b1;
            end
         end else begin
            index_reg <= index_reg + CW'(1);
         end
      end
   end

   // move engine: write one word per request
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg <= DDBC_IDLE;
         bus_req_reg <= 1'b0;
         bus_we_reg <= 1'b0;
         bus_addr_reg <= '0;
         bus_wdata_reg <= '0;
      end else begin
         case (state_reg)
            DDBC_IDLE: begin
               if (halt_req_reg) begin
                  state_reg <= DDBC_HALTED;
               end else if (start_move) begin
                  state_reg <= DDBC_MOVE;
                  bus_req_reg <= 1'b1;
                  bus_we_reg <= 1'b1;
                  bus_wdata_reg <= fixed_reg;
                  bus_addr_reg <= (dst_mode || !double_mode)
                     ? ptr_reg[active_reg] + {index_reg, 2'b00}
                     : fixed_reg;
               end
            end
            DDBC_MOVE: begin
               if (link.bus_ack) begin
                  state_reg <= DDBC_IDLE;
                  bus_req_reg <= 1'b0;
               end
            end
            DDBC_HALTED: begin
               if (!halt_req_reg) state_reg <= DDBC_IDLE;
            end
            default: state_reg <= DDBC_IDLE;
         endcase
      end
   end

   // interrupt status, write one to clear, set wins
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         irq <= 1'b0;
      end else begin
         for (int i = 0; i < DDBC_EV_W; i++) begin
            if (events[i]) begin
               irq_stat_reg[i] <= 1'b1;
            end else if (reg_write && reg_addr == DDBC_OFS_IRQ_STAT && reg_wdata[i]) begin
               irq_stat_reg[i] <= 1'b0;
            end
         end
         if (reg_write && reg_addr == DDBC_OFS_IRQ_MASK) irq_mask_reg <= reg_wdata[DDBC_EV_W-1:0];
         irq <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   // read port, data one cycle after the strobe
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (reg_read) begin
         case (reg_addr)
            DDBC_OFS_MODE: reg_rdata <= {28'h000_0000, shadow_control_mode_reg};
            DDBC_OFS_STATE: reg_rdata <= {26'h000_0000, stopped_reg, active_reg,
               request_lost_flag_reg, frozen_reg, pending_request_state_reg,
               halt_acknowledge_reg};
            DDBC_OFS_PTR0: reg_rdata <= ptr_reg[0];
            DDBC_OFS_PTR1: reg_rdata <= ptr_reg[1];
            DDBC_OFS_FIXED: reg_rdata <= fixed_reg;
            DDBC_OFS_COUNT: reg_rdata <= DDBC_DW'(count_reg);
            DDBC_OFS_IRQ_STAT: reg_rdata <= {29'h0000_0000, irq_stat_reg};
            DDBC_OFS_IRQ_MASK: reg_rdata <= {29'h0000_0000, irq_mask_reg};
            default: reg_rdata <= '0;
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   assign link.bus_req = bus_req_reg;
   assign link.bus_we = bus_we_reg;
   assign link.bus_addr = bus_addr_reg;
   assign link.bus_wdata = bus_wdata_reg;
endmodule

//--- design/ddbc_memory_end.sv
/*
 memory and request-source end: small word memory answering channel moves,
 and a request pulse input passed to the channel.
 assumes the channel holds bus_req until bus_ack.
*/
`timescale 1ns/1ns
module ddbc_memory_end
   import ddbc_pkg::*;
#(
   parameter int DEPTH = 64
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic req_in,
   output logic [DDBC_DW-1:0] last_wdata,
   output logic [DDBC_AW-1:0] last_addr,
   ddbc_if.memory link
);
   logic [DDBC_DW-1:0] mem [DEPTH];
   logic ack_reg;
   logic req_reg;
   logic [DDBC_DW-1:0] rdata_reg;
   logic [$clog2(DEPTH)-1:0] idx;
   assign idx = link.bus_addr[$clog2(DEPTH)+1:2];

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ack_reg <= 1'b0;
         req_reg <= 1'b0;
         rdata_reg <= '0;
         last_wdata <= '0;
         last_addr <= '0;
      end else begin
         req_reg <= req_in;
         ack_reg <= link.bus_req && !ack_reg;
         if (link.bus_req && !ack_reg) begin
            rdata_reg <= mem[idx];
            if (link.bus_we) begin
               mem[idx] <= link.bus_wdata;
               last_wdata <= link.bus_wdata;
               last_addr <= link.bus_addr;
            end
         end
      end
   end
   assign link.bus_ack = ack_reg;
   assign link.hw_req = req_reg;
   assign link.bus_rdata = rdata_reg;
endmodule

//--- tb/ddbc_sva.sv
/*
 link checker: concurrent assertions on the channel to memory signals.
 assumes the bench places it beside the interface; one clock, sync reset.
*/
`timescale 1ns/1ns
module ddbc_sva
   import ddbc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic hw_req,
   input wire logic bus_req,
   input wire logic bus_we,
   input wire logic [DDBC_AW-1:0] bus_addr,
   input wire logic [DDBC_DW-1:0] bus_wdata,
   input wire logic [DDBC_DW-1:0] bus_rdata,
   input wire logic bus_ack
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   sequence s_answer;
      !bus_ack ##1 bus_req && bus_ack;
   endsequence
   sequence s_release;
      !bus_req && !bus_ack;
   endsequence
   a_move_walk: assert property ($rose(bus_req) |-> s_answer ##1 s_release)
      else $error("move did not finish with one ack");
   a_addr_held: assert property (bus_req && !bus_ack |=> bus_req && $stable(bus_addr))
      else $error("move address changed before ack");
   a_data_held: assert property (bus_req && !bus_ack |=> $stable(bus_wdata))
      else $error("move data changed before ack");
   a_ack_single: assert property (bus_ack |=> !bus_ack)
      else $error("ack longer than one cycle");
   a_ack_in_move: assert property (bus_ack |-> bus_req)
      else $error("ack without a move");
   a_req_release: assert property (bus_ack |=> !bus_req)
      else $error("move request held after ack");
   a_write_move: assert property (bus_req |-> bus_we)
      else $error("move is not a write");
   a_no_early_ack: assert property ($rose(bus_req) |-> !bus_ack)
      else $error("ack before move started");
endmodule

//--- tb/ddbc_tb_top.sv
/*
 bench: channel and memory end joined over ddbc_if, driven through the register port.
 assumes the register map and bit positions of ddbc_pkg.
*/
`timescale 1ns/1ns
module ddbc_tb_top;
   import ddbc_pkg::*;
   typedef struct {
      logic [3:0] a;
      logic [31:0] d;
      logic [3:0] be;
      logic [31:0] x;
   } ddbc_row_s;
   logic clk_sys = 1'h0;
   logic reset = 1'h1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic [3:0] reg_be = 4'h0;
   logic reg_write = 1'h0;
   logic reg_read = 1'h0;
   logic req_in = 1'h0;
   logic [31:0] reg_rdata;
   logic [31:0] last_wdata;
   logic [31:0] last_addr;
   logic irq;
   int err_count = 0;
   int check_count = 0;
   ddbc_row_s rows [13];
   ddbc_if link (.clk_sys(clk_sys));
   ddbc_channel #(.CW(16)) i_ddbc_channel (.clk_sys(clk_sys), .reset(reset),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_be(reg_be), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq), .link(link));
   ddbc_memory_end #(.DEPTH(64)) i_ddbc_memory_end (.clk_sys(clk_sys), .reset(reset),
      .req_in(req_in), .last_wdata(last_wdata), .last_addr(last_addr), .link(link));
   ddbc_sva i_ddbc_sva (.clk_sys(clk_sys), .reset(reset), .hw_req(link.hw_req),
      .bus_req(link.bus_req), .bus_we(link.bus_we), .bus_addr(link.bus_addr),
      .bus_wdata(link.bus_wdata), .bus_rdata(link.bus_rdata), .bus_ack(link.bus_ack));
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic conclude();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be = 4'hF);
      @(posedge clk_sys);
      reg_write <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      reg_be <= be;
      @(posedge clk_sys);
      reg_write <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] e, input string n);
      @(posedge clk_sys);
      reg_read <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_read <= 1'h0;
      @(negedge clk_sys);
      chk(n, e, reg_rdata);
   endtask
   // waits for the memory end to record a move at the given address
   task automatic wait_addr(input logic [31:0] e);
      int i;
      for (i = 0; i < 20 && last_addr !== e; i++) @(negedge clk_sys);
      chk("last_addr", e, last_addr);
      if (last_addr !== e)
         conclude();
   endtask
   initial begin
      #2000000;
      err_count++;
      conclude();
   end
   initial begin
      int k;
      rows = '{'{DDBC_OFS_MODE, 32'h0000_0008, 4'hF, 32'h0000_0008},
         '{DDBC_OFS_MODE, 32'h0000_0009, 4'hF, 32'h0000_0009},
         '{DDBC_OFS_MODE, 32'h0000_000A, 4'hF, 32'h0000_000A},
         '{DDBC_OFS_MODE, 32'h0000_000B, 4'hF, 32'h0000_000B},
         '{DDBC_OFS_MODE, 32'h0000_0000, 4'hF, 32'h0000_0000},
         '{DDBC_OFS_PTR0, 32'h0000_0100, 4'hF, 32'h0000_0100},
         '{DDBC_OFS_PTR0, 32'hFFFF_0000, 4'h3, 32'h0000_0100},
         '{DDBC_OFS_PTR1, 32'h0000_0200, 4'hF, 32'h0000_0200},
         '{DDBC_OFS_PTR1, 32'h0000_0000, 4'hC, 32'h0000_0200},
         '{DDBC_OFS_FIXED, 32'h0000_A5A5, 4'hF, 32'h0000_A5A5},
         '{DDBC_OFS_COUNT, 32'h0000_0004, 4'hF, 32'h0000_0004},
         '{DDBC_OFS_IRQ_MASK, 32'h0000_0007, 4'hF, 32'h0000_0007},
         '{4'hF, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000}};
      repeat (10) @(posedge clk_sys);
      reset <= 1'h0;
      rd(DDBC_OFS_COUNT, 32'h0000_0010, "count reset");
      rd(DDBC_OFS_STATE, 32'h0000_0000, "state reset");
      for (k = 0; k < 13; k++) begin
         wr(rows[k].a, rows[k].d, rows[k].be);
         rd(rows[k].a, rows[k].x, "register row");
      end
      // safe switch sequence: halt, request, switch, unhalt
      wr(DDBC_OFS_MODE, 32'h0000_000B);
      wr(DDBC_OFS_CTRL, 32'h0000_0001);
      rd(DDBC_OFS_STATE, 32'h0000_0001, "halt ack");
      wr(DDBC_OFS_CTRL, 32'h0000_0008);
      rd(DDBC_OFS_STATE, 32'h0000_0003, "pending");
      chk("halted addr", 32'h0000_0000, last_addr);
      wr(DDBC_OFS_CTRL, 32'h0000_0004);
      rd(DDBC_OFS_STATE, 32'h0000_0017, "frozen");
      wr(DDBC_OFS_CTRL, 32'h0000_0002);
      wait_addr(32'h0000_0200);
      chk("move data", 32'h0000_A5A5, last_wdata);
      rd(DDBC_OFS_STATE, 32'h0000_0010, "resumed");
      // request arriving while one is pending is lost
      wr(DDBC_OFS_CTRL, 32'h0000_0001);
      wr(DDBC_OFS_CTRL, 32'h0000_0008);
      @(posedge clk_sys);
      req_in <= 1'h1;
      @(posedge clk_sys);
      req_in <= 1'h0;
      rd(DDBC_OFS_IRQ_STAT, 32'h0000_0002, "lost event");
      rd(DDBC_OFS_STATE, 32'h0000_001B, "lost flag");
      chk("irq raised", 32'h0000_0001, {31'h0000_0000, irq});
      wr(DDBC_OFS_IRQ_MASK, 32'h0000_0000);
      repeat (2) @(negedge clk_sys);
      chk("irq masked", 32'h0000_0000, {31'h0000_0000, irq});
      wr(DDBC_OFS_IRQ_MASK, 32'h0000_0007);
      wr(DDBC_OFS_IRQ_STAT, 32'h0000_0002);
      wr(DDBC_OFS_STATE, 32'h0000_0008);
      rd(DDBC_OFS_STATE, 32'h0000_0013, "lost cleared");
      chk("irq cleared", 32'h0000_0000, {31'h0000_0000, irq});
      wr(DDBC_OFS_CTRL, 32'h0000_0002);
      wait_addr(32'h0000_0204);
      // software-only mode stops at buffer end
      wr(DDBC_OFS_MODE, 32'h0000_000A);
      wr(DDBC_OFS_CTRL, 32'h0000_0008);
      wait_addr(32'h0000_0208);
      wr(DDBC_OFS_CTRL, 32'h0000_0008);
      wait_addr(32'h0000_020C);
      wr(DDBC_OFS_CTRL, 32'h0000_0008);
      repeat (8) @(negedge clk_sys);
      chk("stop addr", 32'h0000_020C, last_addr);
      rd(DDBC_OFS_STATE, 32'h0000_0032, "stopped");
      rd(DDBC_OFS_IRQ_STAT, 32'h0000_0005, "done and stop events");
      chk("irq on stop", 32'h0000_0001, {31'h0000_0000, irq});
      wr(DDBC_OFS_CTRL, 32'h0000_0004);
      wait_addr(32'h0000_0100);
      // double source buffering moves to the fixed address
      wr(DDBC_OFS_MODE, 32'h0000_0008);
      wr(DDBC_OFS_CTRL, 32'h0000_0008);
      wait_addr(32'h0000_A5A5);
      // second reset in mid-run
      @(posedge clk_sys);
      reset <= 1'h1;
      repeat (2) @(posedge clk_sys);
      reset <= 1'h0;
      rd(DDBC_OFS_MODE, 32'h0000_0000, "mode after reset");
      rd(DDBC_OFS_STATE, 32'h0000_0000, "state after reset");
      conclude();
   end
endmodule
